//--- rtl/prio_bank_pkg.sv
// Package for the upper interrupt priority bank: offsets, field layout, reset values.
// Assumes an AHB-Lite master with 32-bit single word transfers and one clock domain.
package prio_bank_pkg;

    localparam int NUM_REGS = 7;
    localparam int NUM_SRC = 15;
    localparam int ADDR_W = 5;
    localparam int PRIO_W = 3;

    // Byte offsets of the seven registers.
    localparam logic [ADDR_W-1:0] OFS_TIMER4_CAPCOMP3 = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_UART2_TXRX_EXT2_TIMER5 = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_SERIAL2_EVENT_FAULT = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CAPTURE3 = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_TWOWIRE2_EVENTS = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_CALENDAR_CLOCK = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_CHECKSUM_UART_ERRORS = 5'h18;

    // Implemented-bit masks per register index.
    localparam logic [15:0] MASK_R0 = 16'h7070;
    localparam logic [15:0] MASK_R1 = 16'h7777;
    localparam logic [15:0] MASK_R2 = 16'h0077;
    localparam logic [15:0] MASK_R3 = 16'h0070;
    localparam logic [15:0] MASK_R4 = 16'h0770;
    localparam logic [15:0] MASK_R5 = 16'h0700;
    localparam logic [15:0] MASK_R6 = 16'h7770;

    // Each field resets to 100: level four.
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [15:0] RESET_PATTERN = 16'h4444;
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;

    // Field positions (low bit) within their registers.
    localparam int POS_HI = 12;
    localparam int POS_MID = 8;
    localparam int POS_LO = 4;
    localparam int POS_BOT = 0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;

    typedef struct packed {
        logic [PRIO_W-1:0] timer4_priority;
        logic [PRIO_W-1:0] compare3_priority;
        logic [PRIO_W-1:0] uart2_transmit_priority;
        logic [PRIO_W-1:0] uart2_receive_priority;
        logic [PRIO_W-1:0] external_irq2_priority;
        logic [PRIO_W-1:0] timer5_priority;
        logic [PRIO_W-1:0] serial2_event_priority;
        logic [PRIO_W-1:0] serial2_fault_priority;
        logic [PRIO_W-1:0] capture3_priority;
        logic [PRIO_W-1:0] twowire2_master_priority;
        logic [PRIO_W-1:0] twowire2_slave_priority;
        logic [PRIO_W-1:0] calendar_clock_priority;
        logic [PRIO_W-1:0] checksum_error_priority;
        logic [PRIO_W-1:0] uart2_error_priority;
        logic [PRIO_W-1:0] uart1_error_priority;
    } prio_set_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
    } bus_req_t;

    typedef enum logic [0:0] {
        ST_ADDR = 1'b0,
        ST_DATA = 1'b1
    } bus_state_t;

endpackage

//--- rtl/prio_field_reg.sv
// One sixteen-bit priority register with a mask of implemented bits.
// Assumes a one-cycle write strobe from the bus slave in the same clock domain.
`timescale 1ns/1ps
module prio_field_reg
    import prio_bank_pkg::*;
#(
    parameter logic [15:0] IMPL_MASK = 16'h0000
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Write port
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    // Stored value
    output logic [15:0] value
);
    logic [15:0] value_reg;
    logic [15:0] value_next;

    // Masking at the write keeps unimplemented bits at zero for good.
    assign value_next = wr_en ? (wr_data & IMPL_MASK) : value_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            value_reg <= RESET_PATTERN & IMPL_MASK;
        else
            value_reg <= value_next;
    end

    assign value = value_reg;

    a_unimpl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (value_reg & ~IMPL_MASK) == 16'h0000) else $error("unimplemented bit set");
    a_write_stores: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_en |=> value_reg == ($past(wr_data) & IMPL_MASK)) else $error("write lost");
endmodule // prio_field_reg

//--- rtl/prio_gate.sv
// Turns a priority field and a pending request into a qualified request and level.
// Assumes flag and enable are combined upstream into one pending level.
`timescale 1ns/1ps
module prio_gate
    import prio_bank_pkg::*;
(
    // Inputs
    input wire logic [PRIO_W-1:0] prio,
    input wire logic pending,
    // Outputs
    output logic req,
    output logic [PRIO_W-1:0] level
);
    // A zero field masks the source whatever its flag and enable.
    assign req = pending && (prio != PRIO_OFF);
    // The level equals the field value while req is high, else zero; 111 is the highest, seven.
    assign level = req ? prio : PRIO_OFF;
endmodule // prio_gate

//--- rtl/prio_bank_upper.sv
// AHB-Lite slave holding the upper interrupt priority registers.
// Assumes single 32-bit word transfers; the slave always answers OKAY with no wait state.
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module prio_bank_upper
    import prio_bank_pkg::*;
(
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Requests from sources, flag and enable already combined
    input wire logic [prio_bank_pkg::NUM_SRC-1:0] src_pending,
    // Priorities to the arbitration
    output prio_bank_pkg::prio_set_t prio_out,
    output logic [prio_bank_pkg::NUM_SRC-1:0] src_req,
    output logic [prio_bank_pkg::NUM_SRC*prio_bank_pkg::PRIO_W-1:0] src_level
);
    import prio_bank_pkg::*;

    localparam logic [15:0] MASKS [NUM_REGS] = '{MASK_R0, MASK_R1, MASK_R2, MASK_R3,
        MASK_R4, MASK_R5, MASK_R6};

    function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
        if (a == OFS_TIMER4_CAPCOMP3) return 3'd0;
        else if (a == OFS_UART2_TXRX_EXT2_TIMER5) return 3'd1;
        else if (a == OFS_SERIAL2_EVENT_FAULT) return 3'd2;
        else if (a == OFS_CAPTURE3) return 3'd3;
        else if (a == OFS_TWOWIRE2_EVENTS) return 3'd4;
        else if (a == OFS_CALENDAR_CLOCK) return 3'd5;
        else if (a == OFS_CHECKSUM_UART_ERRORS) return 3'd6;
        else return 3'd7;
    endfunction

    bus_req_t req_reg;
    bus_req_t req_next;
    bus_state_t state_reg;
    bus_state_t state_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic [15:0] regs [NUM_REGS];
    logic [15:0] rd_word;
    logic [2:0] rd_idx;
    logic [2:0] wr_idx;
    logic accept;
    prio_set_t prio_reg;
    prio_set_t prio_next;
    logic [NUM_SRC-1:0] req_comb;
    logic [NUM_SRC*PRIO_W-1:0] level_comb;
    logic [NUM_SRC-1:0] src_req_reg;
    logic [NUM_SRC*PRIO_W-1:0] src_level_reg;
    logic [NUM_SRC-1:0] pend_meta_reg;
    logic [NUM_SRC-1:0] pend_sync_reg;
    logic hreadyout_reg;
    logic hresp_reg;

    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign req_next = accept ? '{write: hwrite, addr: haddr[ADDR_W-1:0]} : '{default: 1'b0};
    assign state_next = accept ? ST_DATA : ST_ADDR;
    assign wr_idx = reg_index(req_reg.addr);
    // Reads are looked up from the address phase and registered so data stand at data phase.
    assign rd_idx = reg_index(haddr[ADDR_W-1:0]);
    assign rd_word = (rd_idx == 3'd7) ? 16'h0000 : regs[rd_idx];
    assign hrdata_next = (accept && !hwrite) ? {16'h0000, rd_word} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_reg <= '{default: 1'b0};
            state_reg <= ST_ADDR;
            hrdata_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
        else
        begin
            req_reg <= req_next;
            state_reg <= state_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
    end

    // A read in the data phase right after a write to the same register sees the old value;
    // the master is expected to leave one transfer between them, a usual AHB-Lite limit.
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++)
        begin : gen_regs
            prio_field_reg #(
                .IMPL_MASK(MASKS[g])
            ) u_reg (
                .hclk(hclk),
                .hresetn(hresetn),
                .wr_en(state_reg == ST_DATA && req_reg.write && wr_idx == 3'(g)),
                .wr_data(hwdata[15:0]),
                .value(regs[g])
            );
        end
    endgenerate

    // Field extraction per register.
    assign prio_next.timer4_priority = regs[0][POS_HI +: PRIO_W];
    assign prio_next.compare3_priority = regs[0][POS_LO +: PRIO_W];
    assign prio_next.uart2_transmit_priority = regs[1][POS_HI +: PRIO_W];
    assign prio_next.uart2_receive_priority = regs[1][POS_MID +: PRIO_W];
    assign prio_next.external_irq2_priority = regs[1][POS_LO +: PRIO_W];
    assign prio_next.timer5_priority = regs[1][POS_BOT +: PRIO_W];
    assign prio_next.serial2_event_priority = regs[2][POS_LO +: PRIO_W];
    assign prio_next.serial2_fault_priority = regs[2][POS_BOT +: PRIO_W];
    assign prio_next.capture3_priority = regs[3][POS_LO +: PRIO_W];
    assign prio_next.twowire2_master_priority = regs[4][POS_MID +: PRIO_W];
    assign prio_next.twowire2_slave_priority = regs[4][POS_LO +: PRIO_W];
    assign prio_next.calendar_clock_priority = regs[5][POS_MID +: PRIO_W];
    assign prio_next.checksum_error_priority = regs[6][POS_HI +: PRIO_W];
    assign prio_next.uart2_error_priority = regs[6][POS_MID +: PRIO_W];
    assign prio_next.uart1_error_priority = regs[6][POS_LO +: PRIO_W];

    // Source 0 is the first struct field, at the top of the packed vector.
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : gen_gates
            prio_gate u_gate (
                .prio(prio_next[(NUM_SRC-1-g)*PRIO_W +: PRIO_W]),
                .pending(pend_sync_reg[g]),
                .req(req_comb[g]),
                .level(level_comb[g*PRIO_W +: PRIO_W])
            );
        end
    endgenerate

    // Pending lines may come from other peripherals' clocks, so they are synchronised.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_meta_reg <= '0;
            pend_sync_reg <= '0;
            prio_reg <= {NUM_SRC{PRIO_RESET}};
            src_req_reg <= '0;
            src_level_reg <= '0;
        end
        else
        begin
            pend_meta_reg <= src_pending;
            pend_sync_reg <= pend_meta_reg;
            prio_reg <= prio_next;
            src_req_reg <= req_comb;
            src_level_reg <= level_comb;
        end
    end

    assign prio_out = prio_reg;
    assign src_req = src_req_reg;
    assign src_level = src_level_reg;
    assign hrdata = hrdata_reg;
    // Zero-wait slave with an always-OKAY answer; both come from flops so every output is registered.
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;

    a_reset_level4: assert property (@(posedge hclk) $rose(hresetn) |->
        prio_reg.timer4_priority == 3'h4) else $error("reset level not four");
    a_write_to_out: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == ST_DATA && req_reg.write && req_reg.addr == OFS_TIMER4_CAPCOMP3)
        |-> ##2 prio_out.timer4_priority == $past(hwdata[14:12], 2))
        else $error("timer4 priority not updated");
    a_zero_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
        (prio_next.timer5_priority == 3'h0) |=> !src_req_reg[5])
        else $error("disabled source requested");
    a_level_equal: assert property (@(posedge hclk) disable iff (!hresetn)
        req_comb[0] |=> src_level_reg[2:0] == $past(prio_next.timer4_priority))
        else $error("level differs from field");
    a_top_level: assert property (@(posedge hclk) disable iff (!hresetn)
        (req_comb[12] && prio_next.checksum_error_priority == 3'h7) |=>
        src_level_reg[38:36] == 3'h7) else $error("level seven lost");
    a_read_upper: assert property (@(posedge hclk) disable iff (!hresetn)
        hrdata[31:16] == 16'h0000) else $error("upper read bits set");
    a_calendar_pos: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> prio_out.calendar_clock_priority == $past(regs[5][10:8]))
        else $error("calendar field misplaced");
    a_read_returns: assert property (@(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && haddr[ADDR_W-1:0] == OFS_CAPTURE3) |=>
        hrdata[15:0] == $past(regs[3])) else $error("read value wrong");
endmodule // prio_bank_upper

//--- sim/tb_prio_bank_upper.sv
// Self-checking bench for the upper interrupt priority bank, driven over AHB-Lite.
// Assumes one slave on the bus: its hreadyout is fed back as hready, and the bench drives
// the pending inputs in place of the interrupt sources.
`timescale 1ns/1ps
module tb_prio_bank_upper;
    import prio_bank_pkg::*;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [NUM_SRC-1:0] src_pending;
    prio_set_t prio_out;
    logic [NUM_SRC-1:0] src_req;
    logic [NUM_SRC*PRIO_W-1:0] src_level;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [15:0] exp_reg [NUM_REGS];
    logic [31:0] rd32;
    // Implemented bits of each register, worked out from the field layout.
    localparam logic [15:0] IMPL [NUM_REGS] = '{16'h7070, 16'h7777, 16'h0077, 16'h0070,
        16'h0770, 16'h0700, 16'h7770};
    localparam logic [ADDR_W-1:0] OFS [NUM_REGS] = '{OFS_TIMER4_CAPCOMP3,
        OFS_UART2_TXRX_EXT2_TIMER5, OFS_SERIAL2_EVENT_FAULT, OFS_CAPTURE3,
        OFS_TWOWIRE2_EVENTS, OFS_CALENDAR_CLOCK, OFS_CHECKSUM_UART_ERRORS};

    prio_bank_upper uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_pending(src_pending),
        .prio_out(prio_out), .src_req(src_req), .src_level(src_level)
    );

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // A hang is cut short well beyond the few hundred cycles the sequence needs.
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Checks run: %0d, mismatches: %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One single word transfer; the upper data half is set to show it is ignored.
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] addr, input logic [15:0] wd,
            output logic [31:0] rdat);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {{(32-ADDR_W){1'b0}}, addr};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {16'hFFFF, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdat = hrdata;
        check("hresp", {63'h0, hresp}, 64'h0);
        check("hreadyout", {63'h0, hreadyout}, 64'h1);
    endtask

    task automatic wr(input int i, input logic [15:0] d);
        bus(1'b1, OFS[i], d, rd32);
        exp_reg[i] = d & IMPL[i];
    endtask

    task automatic rd_chk(input int i);
        bus(1'b0, OFS[i], 16'h0000, rd32);
        check($sformatf("register %0d", i), rd32, {16'h0000, exp_reg[i]});
    endtask

    task automatic reset_exp();
        for (int i = 0; i < NUM_REGS; i++)
            exp_reg[i] = 16'h4444 & IMPL[i];
    endtask

    function automatic prio_set_t exp_prio();
        prio_set_t p;
        p.timer4_priority = exp_reg[0][14:12];
        p.compare3_priority = exp_reg[0][6:4];
        p.uart2_transmit_priority = exp_reg[1][14:12];
        p.uart2_receive_priority = exp_reg[1][10:8];
        p.external_irq2_priority = exp_reg[1][6:4];
        p.timer5_priority = exp_reg[1][2:0];
        p.serial2_event_priority = exp_reg[2][6:4];
        p.serial2_fault_priority = exp_reg[2][2:0];
        p.capture3_priority = exp_reg[3][6:4];
        p.twowire2_master_priority = exp_reg[4][10:8];
        p.twowire2_slave_priority = exp_reg[4][6:4];
        p.calendar_clock_priority = exp_reg[5][10:8];
        p.checksum_error_priority = exp_reg[6][14:12];
        p.uart2_error_priority = exp_reg[6][10:8];
        p.uart1_error_priority = exp_reg[6][6:4];
        return p;
    endfunction

    // Source index 0 is the most significant field of the priority struct.
    task automatic chk_out();
        prio_set_t p;
        logic [NUM_SRC*PRIO_W-1:0] lvl;
        logic [NUM_SRC-1:0] req;
        logic [PRIO_W-1:0] f;
        p = exp_prio();
        for (int i = 0; i < NUM_SRC; i++)
        begin
            f = p[(NUM_SRC-1-i)*PRIO_W +: PRIO_W];
            req[i] = src_pending[i] && (f != 3'h0);
            lvl[i*PRIO_W +: PRIO_W] = req[i] ? f : 3'h0;
        end
        check("prio_out", prio_out, p);
        check("src_req", src_req, req);
        check("src_level", src_level, lvl);
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        src_pending = 15'h0000;
        reset_exp();
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < NUM_REGS; i++)
            rd_chk(i);
        src_pending <= 15'h7FFF;
        repeat (4) @(posedge hclk);
        chk_out();
        // Every spare bit set, and the four field positions carry distinct values.
        for (int i = 0; i < NUM_REGS; i++)
            wr(i, 16'hFEB9);
        repeat (2) @(posedge hclk);
        chk_out();
        for (int i = 0; i < NUM_REGS; i++)
            rd_chk(i);
        // All eight codes on the register with four fields, zero included.
        for (int v = 0; v < 8; v++)
        begin
            wr(1, 16'(v * 16'h1111));
            repeat (2) @(posedge hclk);
            chk_out();
            rd_chk(1);
        end
        src_pending <= 15'h55AA;
        repeat (4) @(posedge hclk);
        chk_out();
        // An unmapped word reads zero and a write there disturbs nothing.
        bus(1'b1, 5'h1C, 16'hFFFF, rd32);
        bus(1'b0, 5'h1C, 16'h0000, rd32);
        check("unmapped", rd32, 64'h0);
        for (int i = 0; i < NUM_REGS; i++)
            rd_chk(i);
        // A second reset in mid-run must bring every field back to level four.
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        reset_exp();
        for (int i = 0; i < NUM_REGS; i++)
            rd_chk(i);
        chk_out();
        test_done();
    end
endmodule // tb_prio_bank_upper
